// ===== dpt_fault_map.vh
// Purpose: Constants for the dead-time PWM fault input block
// Assumes: One clock domain, 16-bit phase counter
// Notes:   Mode codes follow the fault mode select encoding
`ifndef DPT_FAULT_MAP_VH
`define DPT_FAULT_MAP_VH

`define DPT_MODE_NONE    4'h0
`define DPT_MODE_1       4'h1
`define DPT_MODE_2       4'h2
`define DPT_MODE_3       4'h3
`define DPT_MODE_4       4'h4
`define DPT_MODE_5       4'h5
`define DPT_MODE_6       4'h6
`define DPT_MODE_7       4'h7
`define DPT_MODE_8       4'h8
`define DPT_MODE_9       4'h9
`define DPT_MODE_10      4'hA

`define DPT_CNT_RST      16'h0000
`define DPT_LEN_RST      16'h0001

`endif

// ===== dpt_fault.v
// Purpose: Phase sequencer of a two-output dead-time PWM timer with fault input modes
// Assumes: Fault inputs and restart strobe are synchronous to i_ref_clk
// Notes:   Each phase lasts its length input plus one cycle; outputs registered
`timescale 1ns/1ps
`include "dpt_fault_map.vh"

module dpt_fault
(
   // Clock and reset
   input  wire        i_ref_clk,
   input  wire        i_rst_n,
   // Configuration
   input  wire [3:0]  i_fault_mode_select_a,
   input  wire [3:0]  i_fault_mode_select_b,
   input  wire [15:0] i_deadtime_len_a,
   input  wire [15:0] i_ontime_len_a,
   input  wire [15:0] i_deadtime_len_b,
   input  wire [15:0] i_ontime_len_b,
   input  wire        i_restart_cmd,
   // Fault events
   input  wire        i_fault_a,
   input  wire        i_fault_b,
   // Waveform and state
   output reg         o_wave_out_a,
   output reg         o_wave_out_b,
   output reg  [3:0]  o_phase,
   output reg         o_counter_held
);

   localparam [3:0] ST_DTA = 4'b0001;
   localparam [3:0] ST_OTA = 4'b0010;
   localparam [3:0] ST_DTB = 4'b0100;
   localparam [3:0] ST_OTB = 4'b1000;

   reg  [3:0]  phase;
   reg  [15:0] cnt;
   reg         fault_a_q;
   reg         fault_b_q;
   reg         hold_wait;
   reg         stop7;
   reg         blank_a;
   reg         blank_b;
   reg         lock_a;
   reg         lock_b;
   reg  [3:0]  next_phase;
   reg  [15:0] next_cnt;
   reg         next_hold_wait;
   reg         next_stop7;
   reg         next_blank_a;
   reg         next_blank_b;
   reg         next_lock_a;
   reg         next_lock_b;
   reg         phase_end;
   reg  [15:0] cur_len;

   wire rise_a = i_fault_a & ~fault_a_q;
   wire rise_b = i_fault_b & ~fault_b_q;
   wire in_a   = phase[0] | phase[1];
   wire in_b   = phase[2] | phase[3];

   // Mode decode used for both inputs
   function is_mode;
      input [3:0] sel;
      input [3:0] code;
      begin
         is_mode = (sel == code);
      end
   endfunction

   // Any input in a mode shared by both outputs
   function any_mode;
      input [3:0] code;
      input       fa;
      input       fb;
      begin
         any_mode = (is_mode(i_fault_mode_select_a, code) & fa) |
                    (is_mode(i_fault_mode_select_b, code) & fb);
      end
   endfunction

   // Next phase in the normal ring
   function [3:0] ring_next;
      input [3:0] p;
      begin
         case (p)
            ST_DTA:  ring_next = ST_OTA;
            ST_OTA:  ring_next = ST_DTB;
            ST_DTB:  ring_next = ST_OTB;
            ST_OTB:  ring_next = ST_DTA;
            default: ring_next = ST_DTA;
         endcase
      end
   endfunction

   always @*
   begin
      case (phase)
         ST_DTA:  cur_len = i_deadtime_len_a;
         ST_OTA:  cur_len = i_ontime_len_a;
         ST_DTB:  cur_len = i_deadtime_len_b;
         ST_OTB:  cur_len = i_ontime_len_b;
         default: cur_len = `DPT_LEN_RST;
      endcase
      phase_end = (cnt >= cur_len);
   end

   // Sequencer; modes act in priority order when both inputs disagree
   always @*
   begin
      next_phase     = phase;
      next_cnt       = cnt + 16'h0001;
      next_hold_wait = hold_wait;
      next_stop7     = stop7;
      next_lock_a    = lock_a;
      next_lock_b    = lock_b;
      next_blank_a   = blank_a;
      next_blank_b   = blank_b;
      if (phase_end)
      begin
         next_phase   = ring_next(phase);
         next_cnt     = `DPT_CNT_RST;
         next_blank_a = 1'b0;
         next_blank_b = 1'b0;
      end
      // Locks for modes 2 and 3 remember which side is faulted
      if (lock_a & phase_end & phase == ST_OTB)
      begin
         if (i_fault_a & is_mode(i_fault_mode_select_a, `DPT_MODE_3))
            next_phase = ST_DTB;
         else if (i_fault_a)
         begin
            next_phase     = ST_DTA;
            next_hold_wait = 1'b1;
         end
         else
            next_lock_a = 1'b0;
      end
      if (lock_b & phase_end & phase == ST_OTA)
      begin
         if (i_fault_b & is_mode(i_fault_mode_select_b, `DPT_MODE_3))
            next_phase = ST_DTA;
         else if (i_fault_b)
         begin
            next_phase     = ST_DTB;
            next_hold_wait = 1'b1;
         end
         else
            next_lock_b = 1'b0;
      end
      if (in_a & rise_a & (is_mode(i_fault_mode_select_a, `DPT_MODE_2) |
                           is_mode(i_fault_mode_select_a, `DPT_MODE_3)))
      begin
         next_phase  = ST_DTB;
         next_cnt    = `DPT_CNT_RST;
         next_lock_a = 1'b1;
      end
      if (in_b & rise_b & (is_mode(i_fault_mode_select_b, `DPT_MODE_2) |
                           is_mode(i_fault_mode_select_b, `DPT_MODE_3)))
      begin
         next_phase  = ST_DTA;
         next_cnt    = `DPT_CNT_RST;
         next_lock_b = 1'b1;
      end
      // Mode 1: jump and hold at opposite dead-time
      if (is_mode(i_fault_mode_select_a, `DPT_MODE_1) & i_fault_a & (in_a | hold_wait))
      begin
         next_phase     = ST_DTB;
         next_cnt       = `DPT_CNT_RST;
         next_hold_wait = 1'b1;
      end
      if (is_mode(i_fault_mode_select_b, `DPT_MODE_1) & i_fault_b & (in_b | hold_wait))
      begin
         next_phase     = ST_DTA;
         next_cnt       = `DPT_CNT_RST;
         next_hold_wait = 1'b1;
      end
      // Modes 5 and 6: on-time jumps to opposite dead-time
      if (any_mode(`DPT_MODE_5, i_fault_a, i_fault_b) |
          any_mode(`DPT_MODE_6, i_fault_a, i_fault_b))
      begin
         if (phase == ST_OTA | (phase == ST_DTB & phase_end))
         begin
            next_phase = (phase == ST_OTA) ? ST_DTB : ST_DTA;
            next_cnt   = `DPT_CNT_RST;
         end
         else if (phase == ST_OTB | (phase == ST_DTA & phase_end))
         begin
            next_phase = (phase == ST_OTB) ? ST_DTA : ST_DTB;
            next_cnt   = `DPT_CNT_RST;
         end
         if (any_mode(`DPT_MODE_6, i_fault_a, i_fault_b) & (phase_end | phase[1] | phase[3]))
            next_hold_wait = 1'b1;
      end
      // Mode 8: rising edge in own on-time jumps over
      if (is_mode(i_fault_mode_select_a, `DPT_MODE_8) & rise_a & phase == ST_OTA)
      begin
         next_phase = ST_DTB;
         next_cnt   = `DPT_CNT_RST;
      end
      if (is_mode(i_fault_mode_select_b, `DPT_MODE_8) & rise_b & phase == ST_OTB)
      begin
         next_phase = ST_DTA;
         next_cnt   = `DPT_CNT_RST;
      end
      // Modes 9 and 10 blank the rest of the on-time
      if (phase == ST_OTA & ((is_mode(i_fault_mode_select_a, `DPT_MODE_9) & rise_a) |
                             (is_mode(i_fault_mode_select_a, `DPT_MODE_10) & i_fault_a)))
         next_blank_a = ~phase_end;
      if (phase == ST_OTB & ((is_mode(i_fault_mode_select_b, `DPT_MODE_9) & rise_b) |
                             (is_mode(i_fault_mode_select_b, `DPT_MODE_10) & i_fault_b)))
         next_blank_b = ~phase_end;
      // Held counter: stays put until every waiting input has dropped
      if (hold_wait)
      begin
         next_phase = phase;
         next_cnt   = cnt;
         if (!((i_fault_a & (is_mode(i_fault_mode_select_a, `DPT_MODE_1) |
                             is_mode(i_fault_mode_select_a, `DPT_MODE_2) |
                             is_mode(i_fault_mode_select_a, `DPT_MODE_6))) |
               (i_fault_b & (is_mode(i_fault_mode_select_b, `DPT_MODE_1) |
                             is_mode(i_fault_mode_select_b, `DPT_MODE_2) |
                             is_mode(i_fault_mode_select_b, `DPT_MODE_6)))))
         begin
            next_hold_wait = 1'b0;
            next_lock_a    = 1'b0;
            next_lock_b    = 1'b0;
            if (phase[1] | phase[3])
               next_phase = ring_next(phase);
         end
      end
      // Mode 7 stop wins over everything; restart resumes at dead-time A
      if (stop7)
      begin
         next_phase = phase;
         next_cnt   = cnt;
         if (i_restart_cmd)
         begin
            next_stop7     = 1'b0;
            next_phase     = ST_DTA;
            next_cnt       = `DPT_CNT_RST;
            next_hold_wait = 1'b0;
            next_lock_a    = 1'b0;
            next_lock_b    = 1'b0;
         end
      end
      if (any_mode(`DPT_MODE_7, i_fault_a, i_fault_b))
      begin
         next_stop7 = 1'b1;
         if (!stop7)
         begin
            next_phase = phase;
            next_cnt   = cnt;
         end
      end
      // Mode 0 and codes above ten never reach any branch above
   end

   always @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         phase          <= ST_DTA;
         cnt            <= `DPT_CNT_RST;
         fault_a_q      <= 1'b0;
         fault_b_q      <= 1'b0;
         hold_wait      <= 1'b0;
         stop7          <= 1'b0;
         lock_a         <= 1'b0;
         lock_b         <= 1'b0;
         blank_a        <= 1'b0;
         blank_b        <= 1'b0;
         o_wave_out_a   <= 1'b0;
         o_wave_out_b   <= 1'b0;
         o_phase        <= ST_DTA;
         o_counter_held <= 1'b0;
      end
      else
      begin
         phase          <= next_phase;
         cnt            <= next_cnt;
         fault_a_q      <= i_fault_a;
         fault_b_q      <= i_fault_b;
         hold_wait      <= next_hold_wait;
         stop7          <= next_stop7;
         lock_a         <= next_lock_a;
         lock_b         <= next_lock_b;
         blank_a        <= next_blank_a;
         blank_b        <= next_blank_b;
         o_phase        <= next_phase;
         o_counter_held <= next_hold_wait | next_stop7;
         // Outputs follow next phase, so they drop with the jump, not a cycle later
         o_wave_out_a   <= (next_phase == ST_OTA) & ~next_blank_a & ~next_hold_wait &
                           ~next_stop7 &
                           ~any_mode(`DPT_MODE_4, i_fault_a, i_fault_b) &
                           ~any_mode(`DPT_MODE_5, i_fault_a, i_fault_b) &
                           ~any_mode(`DPT_MODE_6, i_fault_a, i_fault_b) &
                           ~(is_mode(i_fault_mode_select_a, `DPT_MODE_10) &
                             i_fault_a);
         o_wave_out_b   <= (next_phase == ST_OTB) & ~next_blank_b & ~next_hold_wait &
                           ~next_stop7 &
                           ~any_mode(`DPT_MODE_4, i_fault_a, i_fault_b) &
                           ~any_mode(`DPT_MODE_5, i_fault_a, i_fault_b) &
                           ~any_mode(`DPT_MODE_6, i_fault_a, i_fault_b) &
                           ~(is_mode(i_fault_mode_select_b, `DPT_MODE_10) & i_fault_b);
      end
   end

endmodule

// ===== dpt_fault_sva.sv
// Purpose: Port checks for the fault input phase sequencer
// Assumes: One clock domain, asynchronous low reset
// Notes:   Mode four and seven checks expect the same mode on both inputs; mode eight and ten checks look at input A only
`timescale 1ns/1ps
module dpt_fault_sva
(
   // Clock and reset
   input wire       i_ref_clk,
   input wire       i_rst_n,
   // Inputs watched
   input wire [3:0] i_fault_mode_select_a,
   input wire [3:0] i_fault_mode_select_b,
   input wire       i_restart_cmd,
   input wire       i_fault_a,
   input wire       i_fault_b,
   // Outputs watched
   input wire       o_wave_out_a,
   input wire       o_wave_out_b,
   input wire [3:0] o_phase,
   input wire       o_counter_held
);
   wire [3:0] ma = i_fault_mode_select_a;
   wire [3:0] mb = i_fault_mode_select_b;
   wire       idle = (ma == 4'h0 || ma > 4'hA) && (mb == 4'h0 || mb > 4'hA);
   wire       m7 = ma == 4'h7 && mb == 4'h7;
   wire       f = i_fault_a || i_fault_b;
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   phase_onehot_a: assert property ($onehot(o_phase))
      else $error("phase not one-hot");
   wave_in_ota_a: assert property (o_wave_out_a |-> o_phase == 4'h2)
      else $error("wave a outside on-time a");
   wave_in_otb_a: assert property (o_wave_out_b |-> o_phase == 4'h8)
      else $error("wave b outside on-time b");
   idle_wave_a: assert property (idle |=>
      o_wave_out_a == o_phase[1] && o_wave_out_b == o_phase[3])
      else $error("idle mode touched waves");
   idle_no_hold_a: assert property (idle |=> !o_counter_held)
      else $error("idle mode held counter");
   all_off_a: assert property (ma == 4'h4 && mb == 4'h4 && f |=>
      !o_wave_out_a && !o_wave_out_b)
      else $error("mode four left a wave on");
   stop_hold_a: assert property (m7 && f |=>
      o_counter_held && !o_wave_out_a && !o_wave_out_b)
      else $error("mode seven did not stop");
   hold_freeze_a: assert property (m7 && o_counter_held && !i_restart_cmd |=>
      $stable(o_phase))
      else $error("phase moved while stopped");
   restart_dta_a: assert property (m7 && o_counter_held && i_restart_cmd && !f |=>
      o_phase == 4'h1 && !o_counter_held)
      else $error("restart not at dead-time a");
   edge_jump_a: assert property (ma == 4'h8 && $rose(i_fault_a) && o_phase == 4'h2 |=>
      o_phase == 4'h4 && !o_wave_out_a)
      else $error("edge did not jump to dead-time b");
   level_off_a: assert property (ma == 4'hA && i_fault_a |=> !o_wave_out_a)
      else $error("level did not hold wave a off");
   cover property (m7 && o_counter_held);
   cover property (ma == 4'h8 && $rose(i_fault_a) && o_phase == 4'h2);
   cover property (ma == 4'h4 && i_fault_a);
endmodule

bind dpt_fault dpt_fault_sva chk
(
   .i_ref_clk             (i_ref_clk),
   .i_rst_n               (i_rst_n),
   .i_fault_mode_select_a (i_fault_mode_select_a),
   .i_fault_mode_select_b (i_fault_mode_select_b),
   .i_restart_cmd         (i_restart_cmd),
   .i_fault_a             (i_fault_a),
   .i_fault_b             (i_fault_b),
   .o_wave_out_a          (o_wave_out_a),
   .o_wave_out_b          (o_wave_out_b),
   .o_phase               (o_phase),
   .o_counter_held        (o_counter_held)
);

// ===== dpt_evt_src.sv
// Purpose: Event routing model feeding the fault inputs
// Assumes: Requests change at the falling edge
// Notes:   One stage of delay, so events never move at the sampling edge
`timescale 1ns/1ps
module dpt_evt_src
(
   // Clock and reset
   input  wire i_ref_clk,
   input  wire i_rst_n,
   // Requests
   input  wire i_req_a,
   input  wire i_req_b,
   // Routed events
   output reg  o_fault_a,
   output reg  o_fault_b
);
   always @(negedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_fault_a <= 1'b0;
         o_fault_b <= 1'b0;
      end
      else
      begin
         o_fault_a <= i_req_a;
         o_fault_b <= i_req_b;
      end
   end
endmodule

// ===== test_pwm_fault_input_modes.sv
// Purpose: Scenario bench for the fault input phase sequencer
// Assumes: Inputs move at the falling edge
// Notes:   Short phase lengths keep the run small
`timescale 1ns/1ps
module test_pwm_fault_input_modes;
   localparam [15:0] LDA = 16'h0001;
   localparam [15:0] LOA = 16'h0005;
   localparam [15:0] LDB = 16'h0002;
   localparam [15:0] LOB = 16'h0004;
   reg        clk = 1'b0;
   reg        rst_n = 1'b0;
   reg  [3:0] mode = 4'h0;
   reg        rq_a = 1'b0;
   reg        rq_b = 1'b0;
   reg        rs = 1'b0;
   wire       fa;
   wire       fb;
   wire       wa;
   wire       wb;
   wire [3:0] ph;
   wire       hd;
   integer    err_total = 0;
   integer    n_tests = 0;
   always #10 clk = ~clk;
   dpt_evt_src u_evt (.i_ref_clk(clk), .i_rst_n(rst_n), .i_req_a(rq_a), .i_req_b(rq_b),
      .o_fault_a(fa), .o_fault_b(fb));
   // Same mode on both inputs avoids conflicts on the shared counter
   dpt_fault uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_fault_mode_select_a(mode),
      .i_fault_mode_select_b(mode), .i_deadtime_len_a(LDA), .i_ontime_len_a(LOA),
      .i_deadtime_len_b(LDB), .i_ontime_len_b(LOB), .i_restart_cmd(rs), .i_fault_a(fa),
      .i_fault_b(fb), .o_wave_out_a(wa), .o_wave_out_b(wb), .o_phase(ph), .o_counter_held(hd));
   task chk(input [15:0] got, input [15:0] exp);
   begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task tick(input integer n);
   begin
      repeat (n) @(negedge clk);
   end
   endtask
   task put(input a, input b);
   begin
      rq_a <= a;
      rq_b <= b;
      tick(1);
   end
   endtask
   task pulse;
   begin
      rs <= 1'b1;
      tick(1);
      rs <= 1'b0;
      tick(1);
   end
   endtask
   task seek(input [3:0] p);
      integer k;
   begin
      k = 0;
      while (ph !== p && k < 100)
      begin
         tick(1);
         k = k + 1;
      end
      chk(ph, p);
   end
   endtask
   task ring(input [3:0] m, input on);
      integer k;
      integer n;
   begin
      mode <= m;
      put(1, 1);
      seek(4'h8);
      seek(4'h1);
      for (k = 0; k < 4; k = k + 1)
      begin
         n = 0;
         while (ph === (4'h1 << k) && n < 50)
         begin
            chk({wa, wb}, {on & k == 1, on & k == 3});
            n = n + 1;
            tick(1);
         end
         chk(n, k == 0 ? LDA + 1 : k == 1 ? LOA + 1 : k == 2 ? LDB + 1 : LOB + 1);
      end
      put(0, 0);
   end
   endtask
   task run(input [3:0] m, input [3:0] forbid, input [3:0] fin, input hold);
      reg [3:0] seen;
      reg       w;
   begin
      mode <= m;
      seek(4'h2);
      put(1, 0);
      tick(1);
      seen = 4'h0;
      w = 1'b0;
      repeat (20)
      begin
         seen = seen | ph;
         w = w | wa;
         tick(1);
      end
      chk(seen & forbid, 4'h0);
      chk(w, 1'b0);
      chk(hd, hold);
      if (fin != 4'h0)
         chk(ph, fin);
      put(0, 0);
      seek(4'h1);
   end
   endtask
   task edge_case(input [3:0] m);
   begin
      mode <= m;
      seek(4'h2);
      put(1, 0);
      tick(1);
      chk({wa, ph}, m == 4'h8 ? 5'h04 : 5'h02);
      put(0, 0);
      tick(1);
      chk({wa, ph}, m == 4'h8 ? 5'h04 : 5'h02);
      seek(4'h1);
   end
   endtask
   task stop7;
      reg [3:0] p;
   begin
      mode <= 4'h7;
      put(1, 0);
      tick(1);
      p = ph;
      chk({hd, wa, wb}, 3'h4);
      put(0, 0);
      tick(4);
      chk(ph, p);
      pulse;
      chk({hd, ph}, 5'h01);
      put(1, 0);
      tick(1);
      pulse;
      chk(hd, 1'b1);
      put(0, 0);
      pulse;
   end
   endtask
   // One-cycle event in on-time A: opposite phases run, then no wait
   task brief;
   begin
      mode <= 4'h2;
      seek(4'h2);
      put(1, 0);
      put(0, 0);
      chk(ph, 4'h4);
      seek(4'h1);
      chk(hd, 1'b0);
      tick(3);
      chk(ph, 4'h2);
   end
   endtask
   // Input B alone: ignored outside its phases, edge in on-time B jumps
   task side_b;
   begin
      mode <= 4'h2;
      seek(4'h2);
      put(0, 1);
      tick(1);
      chk({wa, ph}, 5'h12);
      put(0, 0);
      mode <= 4'h8;
      seek(4'h8);
      put(0, 1);
      tick(1);
      chk({wb, ph}, 5'h01);
      put(0, 0);
      seek(4'h1);
   end
   endtask
   task stop_test;
   begin
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   initial
   begin
      #200000;
      err_total = err_total + 1;
      stop_test;
   end
   initial
   begin
      tick(8);
      rst_n = 1'b1;
      ring(4'h0, 1'b1);
      ring(4'hB, 1'b1);
      ring(4'h4, 1'b0);
      ring(4'hA, 1'b0);
      run(4'h1, 4'hA, 4'h4, 1'b1);
      run(4'h2, 4'h2, 4'h1, 1'b1);
      run(4'h3, 4'h1, 4'h0, 1'b0);
      run(4'h5, 4'hA, 4'h0, 1'b0);
      run(4'h6, 4'hA, 4'h4, 1'b1);
      edge_case(4'h8);
      edge_case(4'h9);
      edge_case(4'hA);
      brief;
      side_b;
      stop7;
      stop_test;
   end
endmodule
